// ==== hdl/eeprom_params.svh ====
// constants for the two-wire serial memory sequencer
`ifndef EEPROM_PARAMS_SVH
`define EEPROM_PARAMS_SVH
`define CLK_PERIOD_PS      5000
`define PROG_TIME_MS       5
`define TYPE_CODE          4'hA
`define ADDR_BITS          13
`define PAGE_BITS          5
`define PAGE_BYTES         32
`define FIFO_DEPTH         32
`define ADDR_RESET         13'h0000
`define BYTE_BITS          8
`define BIT_LAST           4'h7
`define BIT_ACK            4'h8
`endif

// ==== hdl/eeprom_pkg.sv ====
// types shared by the sequencer modules
package eeprom_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_DEVA  = 3'b001,
        ST_WADDR = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100,
        ST_PROG  = 3'b101
    } seq_state_t;
endpackage

// ==== hdl/byte_stream_if.sv ====
// valid/ready byte stream between sequencer and page buffer
`timescale 1ns/1ps
interface byte_stream_if #(parameter int WIDTH = 8);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ==== hdl/stream_fifo.sv ====
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`include "eeprom_params.svh"
module stream_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input  wire logic  core_clk_in,
    input  wire logic  resetn_in,
    input  wire logic  flush_in,
    byte_stream_if.snk wr,
    byte_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0]      wp_ff;
    logic [AW:0]      rp_ff;
    wire              full  = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
    wire              empty = (wp_ff == rp_ff);
    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data  = mem_ff[rp_ff[AW-1:0]];
    always_ff @(posedge core_clk_in) begin
        if (wr.valid && !full) begin
            mem_ff[wp_ff[AW-1:0]] <= wr.data;
        end
    end
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else if (flush_in) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else begin
            if (wr.valid && !full) begin
                wp_ff <= wp_ff + 1'b1;
            end
            if (rd.ready && !empty) begin
                rp_ff <= rp_ff + 1'b1;
            end
        end
    end
    AST_FIFO_NO_OVERRUN: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        full && !(rd.ready) && !flush_in |=> $stable(wp_ff))
        else $error("fifo write pointer moved while full");
endmodule // stream_fifo

// ==== hdl/pin_sync.sv ====
// three-stage synchroniser with agreement of last two stages
`timescale 1ns/1ps
module pin_sync (
    input  wire logic clk_in,
    input  wire logic resetn_in,
    input  wire logic pin_in,
    output logic      level_out
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s1_ff     <= 1'b1;
            s2_ff     <= 1'b1;
            s3_ff     <= 1'b1;
            level_out <= 1'b1;
        end else begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff) begin
                level_out <= s3_ff;
            end
        end
    end
endmodule // pin_sync

// ==== hdl/eeprom_seq.sv ====
// two-wire serial memory command sequencer, target side
`timescale 1ns/1ps
`include "eeprom_params.svh"
module eeprom_seq #(
    // per-millisecond count first: the full product overflows a 32-bit int
    parameter int PROG_CYCLES = `PROG_TIME_MS * (1000000000 / `CLK_PERIOD_PS),
    parameter int AW          = `ADDR_BITS
) (
    input  wire logic       core_clk_in,
    input  wire logic       resetn_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    input  wire logic [2:0] chip_select_pins_in,
    input  wire logic       write_protect_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    output logic            busy_out
);
    localparam int PCW = $clog2(PROG_CYCLES + 1);
    logic                 scl_s;
    logic                 sda_s;
    logic                 scl_d_ff;
    logic                 sda_d_ff;
    eeprom_pkg::seq_state_t state_ff;
    logic [3:0]           bit_ff;
    logic [7:0]           shift_ff;
    logic                 ack_phase_ff;
    logic                 nack_ff;
    logic                 rd_mode_ff;
    logic                 addr_hi_ff;
    logic [AW-1:0]        addr_ff;
    logic [PCW-1:0]       prog_cnt_ff;
    logic [7:0]           mem_ff [2**AW];
    logic [7:0]           rd_byte;
    logic                 prog_pending_ff;
    logic                 dev_ack_rd;
    byte_stream_if #(.WIDTH(AW+8)) wr_if ();
    byte_stream_if #(.WIDTH(AW+8)) rd_if ();

    pin_sync u_scl_sync (.clk_in(core_clk_in), .resetn_in(resetn_in), .pin_in(scl_in), .level_out(scl_s));
    pin_sync u_sda_sync (.clk_in(core_clk_in), .resetn_in(resetn_in), .pin_in(sda_in), .level_out(sda_s));

    wire scl_rise  = scl_s && !scl_d_ff;
    wire scl_fall  = !scl_s && scl_d_ff;
    wire start_det = scl_s && scl_d_ff && sda_d_ff && !sda_s;
    wire stop_det  = scl_s && scl_d_ff && !sda_d_ff && sda_s;
    wire [7:0] byte_in = {shift_ff[6:0], sda_s};
    wire dev_match = (byte_in[7:4] == `TYPE_CODE) && (byte_in[3:1] == chip_select_pins_in);
    wire byte_done = scl_rise && !ack_phase_ff && (bit_ff == `BIT_LAST);
    wire [AW-1:0] page_next = {addr_ff[AW-1:`PAGE_BITS], addr_ff[`PAGE_BITS-1:0] + 1'b1};
    wire [AW-1:0] seq_next  = addr_ff + 1'b1;

    // page bytes are buffered and only committed after the stop
    stream_fifo #(.WIDTH(AW+8), .DEPTH(`FIFO_DEPTH)) u_page_buf (
        .core_clk_in (core_clk_in),
        .resetn_in   (resetn_in),
        .flush_in    (start_det && state_ff != eeprom_pkg::ST_PROG),
        .wr          (wr_if.snk),
        .rd          (rd_if.src)
    );

    assign rd_byte = mem_ff[addr_ff];
    assign wr_if.data  = {addr_ff, byte_in};
    assign wr_if.valid = byte_done && state_ff == eeprom_pkg::ST_WDATA;
    assign rd_if.ready = state_ff == eeprom_pkg::ST_PROG && prog_cnt_ff == '0;

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
    end

    // bit counter and receive shift register
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            bit_ff       <= 4'h0;
            shift_ff     <= 8'h00;
            ack_phase_ff <= 1'b0;
            nack_ff      <= 1'b0;
        end else if (start_det) begin
            bit_ff       <= 4'h0;
            ack_phase_ff <= 1'b0;
        end else if (scl_rise) begin
            if (ack_phase_ff) begin
                nack_ff      <= sda_s;
                ack_phase_ff <= 1'b0;
                bit_ff       <= 4'h0;
            end else begin
                shift_ff <= byte_in;
                if (bit_ff == `BIT_LAST) begin
                    ack_phase_ff <= 1'b1;
                end else begin
                    bit_ff <= bit_ff + 1'b1;
                end
            end
        end
    end

    // command state machine
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_ff        <= eeprom_pkg::ST_IDLE;
            rd_mode_ff      <= 1'b0;
            addr_hi_ff      <= 1'b0;
            prog_pending_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                eeprom_pkg::ST_PROG: begin
                    // all bus activity ignored until the array is written
                    if (prog_cnt_ff == '0 && !rd_if.valid) begin
                        state_ff <= eeprom_pkg::ST_IDLE;
                    end
                end
                default: begin
                    if (start_det) begin
                        state_ff        <= eeprom_pkg::ST_DEVA;
                        prog_pending_ff <= 1'b0;
                    end else if (stop_det) begin
                        if (prog_pending_ff) begin
                            state_ff <= eeprom_pkg::ST_PROG;
                        end else begin
                            state_ff <= eeprom_pkg::ST_IDLE;
                        end
                        prog_pending_ff <= 1'b0;
                    end else if (byte_done) begin
                        unique case (state_ff)
                            eeprom_pkg::ST_DEVA: begin
                                rd_mode_ff <= byte_in[0];
                                addr_hi_ff <= 1'b1;
                                if (!dev_match) begin
                                    state_ff <= eeprom_pkg::ST_IDLE;
                                end else if (byte_in[0]) begin
                                    state_ff <= eeprom_pkg::ST_RDATA;
                                end else begin
                                    state_ff <= eeprom_pkg::ST_WADDR;
                                end
                            end
                            eeprom_pkg::ST_WADDR: begin
                                addr_hi_ff <= 1'b0;
                                if (!addr_hi_ff) begin
                                    state_ff <= eeprom_pkg::ST_WDATA;
                                end
                            end
                            eeprom_pkg::ST_WDATA: begin
                                prog_pending_ff <= !write_protect_in;
                            end
                            default: begin
                            end
                        endcase
                    end else if (state_ff == eeprom_pkg::ST_RDATA && scl_rise && ack_phase_ff && sda_s) begin
                        state_ff <= eeprom_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // word address counter; no reset beyond power-up value
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            addr_ff <= `ADDR_RESET;
        end else if (byte_done && state_ff == eeprom_pkg::ST_WADDR) begin
            if (addr_hi_ff) begin
                addr_ff[AW-1:8] <= byte_in[AW-9:0];
            end else begin
                addr_ff[7:0] <= byte_in;
            end
        end else if (byte_done && state_ff == eeprom_pkg::ST_WDATA) begin
            addr_ff <= page_next;
        end else if (state_ff == eeprom_pkg::ST_RDATA && scl_rise && !ack_phase_ff && bit_ff == `BIT_LAST) begin
            addr_ff <= seq_next;
        end
    end

    // program cycle timer and array commit from the page buffer
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            prog_cnt_ff <= '0;
        end else if (state_ff != eeprom_pkg::ST_PROG && stop_det && prog_pending_ff) begin
            prog_cnt_ff <= PCW'(PROG_CYCLES - 1 - `PAGE_BYTES);
        end else if (prog_cnt_ff != '0) begin
            prog_cnt_ff <= prog_cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rd_if.valid && rd_if.ready) begin
            mem_ff[rd_if.data[AW+7:8]] <= rd_if.data[7:0];
        end
    end

    // sda drive: ack low, read bits shifted out after scl falls
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sda_out    <= 1'b1;
            sda_oe_out <= 1'b0;
        end else if (start_det || stop_det || state_ff == eeprom_pkg::ST_PROG) begin
            sda_out    <= 1'b1;
            sda_oe_out <= 1'b0;
        end else if (scl_fall) begin
            sda_out    <= 1'b1;
            sda_oe_out <= 1'b0;
            if (ack_phase_ff && !(state_ff == eeprom_pkg::ST_RDATA && rd_mode_ff && bit_ff == 4'h0
                                   && shift_ff[0] == 1'b1 && !dev_ack_rd)) begin
                if (state_ff != eeprom_pkg::ST_IDLE && !(state_ff == eeprom_pkg::ST_RDATA && !dev_ack_rd)) begin
                    sda_out    <= 1'b0;
                    sda_oe_out <= 1'b1;
                end
            end else if (state_ff == eeprom_pkg::ST_RDATA && !ack_phase_ff && !(bit_ff == 4'h0 && nack_ff && !dev_ack_rd)) begin
                sda_out    <= 1'b0;
                sda_oe_out <= !rd_byte[3'(`BIT_LAST - bit_ff)];
            end
        end
    end

    // marks the ack slot right after the read device address
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dev_ack_rd <= 1'b0;
        end else if (byte_done) begin
            dev_ack_rd <= state_ff == eeprom_pkg::ST_DEVA && dev_match && byte_in[0];
        end else if (scl_rise && ack_phase_ff) begin
            dev_ack_rd <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            busy_out <= 1'b0;
        end else begin
            busy_out <= state_ff == eeprom_pkg::ST_PROG;
        end
    end

    AST_NO_DRIVE_IN_PROG: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        state_ff == eeprom_pkg::ST_PROG ##1 state_ff == eeprom_pkg::ST_PROG |-> !sda_oe_out)
        else $error("sda driven during program cycle");
    AST_PROG_AFTER_STOP: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        stop_det && prog_pending_ff && state_ff != eeprom_pkg::ST_PROG |=> state_ff == eeprom_pkg::ST_PROG)
        else $error("stop after write did not start programming");
    AST_WP_BLOCKS: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        byte_done && state_ff == eeprom_pkg::ST_WDATA && write_protect_in |=> !prog_pending_ff)
        else $error("write protect ignored");
    AST_PAGE_WRAP: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        byte_done && state_ff == eeprom_pkg::ST_WDATA |=> addr_ff[AW-1:5] == $past(addr_ff[AW-1:5]))
        else $error("page row changed during page write");
    AST_READ_INC: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        state_ff == eeprom_pkg::ST_RDATA && scl_rise && !ack_phase_ff && bit_ff == `BIT_LAST
        |=> addr_ff == AW'($past(addr_ff) + 1))
        else $error("read counter did not advance");
    AST_START_CANCELS: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        start_det && state_ff != eeprom_pkg::ST_PROG |=> !prog_pending_ff)
        else $error("start did not cancel pending write");
    AST_BAD_ADDR_IDLE: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        byte_done && state_ff == eeprom_pkg::ST_DEVA && !dev_match |=> state_ff == eeprom_pkg::ST_IDLE)
        else $error("unmatched device address accepted");
    AST_PROG_BOUNDED: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        prog_cnt_ff <= PCW'(PROG_CYCLES))
        else $error("program timer beyond limit");
    COV_WRITE: cover property (@(posedge core_clk_in) state_ff == eeprom_pkg::ST_PROG);
    COV_READ: cover property (@(posedge core_clk_in) state_ff == eeprom_pkg::ST_RDATA);
    COV_WP: cover property (@(posedge core_clk_in) byte_done && write_protect_in);
endmodule // eeprom_seq

// ==== testbench/twi_host_model.sv ====
// two-wire bus controller model driving the serial clock and data lines
`timescale 1ns/1ps
module twi_host_model (
    input  wire logic clk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_out
);
    // clock stands high between frames; data released means pulled up
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // data moves only well inside the low phase, away from either clock edge
    // bit rate scaled to the core clock so the run stays short
    task automatic clock_bit(input logic b, output logic seen);
        wait_cyc(4);
        sda_out = b;
        wait_cyc(9);
        scl_out = 1'b1;
        wait_cyc(12);
        seen = sda_in;
        scl_out = 1'b0;
    endtask

    task automatic send_start();
        wait_cyc(4);
        sda_out = 1'b1;
        wait_cyc(9);
        scl_out = 1'b1;
        wait_cyc(12);
        sda_out = 1'b0;
        wait_cyc(12);
        scl_out = 1'b0;
    endtask

    task automatic send_stop();
        wait_cyc(4);
        sda_out = 1'b0;
        wait_cyc(9);
        scl_out = 1'b1;
        wait_cyc(12);
        sda_out = 1'b1;
        wait_cyc(12);
    endtask

    task automatic send_byte(input logic [7:0] b, output logic acked);
        logic s;
        for (int i = 7; i >= 0; i--) clock_bit(b[i], s);
        clock_bit(1'b1, s);
        acked = ~s;
    endtask

    task automatic recv_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, s);
            b[i] = s;
        end
        clock_bit(~ack, s);
    endtask
endmodule // twi_host_model

// ==== testbench/tb_serial_eeprom_rw_sequencer.sv ====
// self-checking bench for the serial memory command sequencer
`timescale 1ns/1ps
`include "eeprom_params.svh"
module tb_serial_eeprom_rw_sequencer;
    localparam int         PROG  = 2000;
    localparam int         LIMIT = 90000;
    localparam logic [2:0] CS    = 3'h5;
    logic       core_clk;
    logic       resetn;
    logic       wp;
    logic       scl;
    logic       host_sda;
    logic       sda_o;
    logic       sda_oe;
    logic       busy;
    wire logic  sda_wire = host_sda & ~sda_oe;
    int         failures = 0;
    int         cmp_count = 0;
    int         cycles = 0;
    logic [7:0] mem [logic [12:0]];

    eeprom_seq #(.PROG_CYCLES(PROG)) eeprom_seq_inst (
        .core_clk_in(core_clk), .resetn_in(resetn), .scl_in(scl), .sda_in(sda_wire),
        .chip_select_pins_in(CS), .write_protect_in(wp), .sda_out(sda_o),
        .sda_oe_out(sda_oe), .busy_out(busy));
    twi_host_model twi_host_model_inst (.clk_in(core_clk), .sda_in(sda_wire), .scl_out(scl), .sda_out(host_sda));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // a hung handshake would otherwise stall the run forever
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            finish_test();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic dev(input logic rw, output logic ok);
        twi_host_model_inst.send_start();
        twi_host_model_inst.send_byte({`TYPE_CODE, CS, rw}, ok);
    endtask

    // top bits of the high byte set on purpose: they must be ignored
    task automatic set_addr(input logic [12:0] a);
        logic ok;
        dev(1'b0, ok);
        check(ok, 1'b1);
        twi_host_model_inst.send_byte({3'h7, a[12:8]}, ok);
        check(ok, 1'b1);
        twi_host_model_inst.send_byte(a[7:0], ok);
        check(ok, 1'b1);
    endtask

    task automatic write_frame(input logic [12:0] a, input logic [7:0] d[$]);
        logic ok;
        int   t0;
        set_addr(a);
        foreach (d[i]) begin
            twi_host_model_inst.send_byte(d[i], ok);
            check(ok, 1'b1);
            if (!wp) mem[{a[12:5], 5'(a[4:0] + 5'(i))}] = d[i];
        end
        twi_host_model_inst.send_stop();
        t0 = cycles;
        if (!wp) begin
            check(busy, 1'b1);
            dev(1'b0, ok);
            check(ok, 1'b0);
            twi_host_model_inst.send_stop();
        end
        while (busy === 1'b1 && cycles - t0 < PROG + 50) @(posedge core_clk);
        #1;
        check(busy, 1'b0);
        dev(1'b0, ok);
        check(ok, 1'b1);
        twi_host_model_inst.send_stop();
    endtask

    // dummy write then repeated start: the pending write must be dropped
    task automatic read_frame(input logic [12:0] a, input int n);
        logic       ok;
        logic [7:0] b;
        set_addr(a);
        dev(1'b1, ok);
        check(ok, 1'b1);
        for (int i = 0; i < n; i++) begin
            twi_host_model_inst.recv_byte(i < n - 1, b);
            check(b, mem[13'(a + 13'(i))]);
        end
        twi_host_model_inst.send_stop();
        check(busy, 1'b0);
    endtask

    task automatic t_byte_write();
        write_frame(13'h0100, '{8'hA5});
        read_frame(13'h0100, 1);
    endtask

    task automatic t_page_cross();
        write_frame(13'h001E, '{8'h11, 8'h22, 8'h33, 8'h44});
        read_frame(13'h001E, 2);
        read_frame(13'h0000, 2);
    endtask

    task automatic t_top_wrap();
        logic       ok;
        logic [7:0] b;
        write_frame(13'h1FFF, '{8'h5A});
        read_frame(13'h1FFF, 2);
        read_frame(13'h1FFF, 1);
        dev(1'b1, ok);
        check(ok, 1'b1);
        twi_host_model_inst.recv_byte(1'b0, b);
        check(b, mem[13'h0000]);
        twi_host_model_inst.send_stop();
    endtask

    task automatic t_protect();
        @(posedge core_clk);
        #1 wp = 1'b1;
        write_frame(13'h0100, '{8'h3C});
        read_frame(13'h0100, 1);
        @(posedge core_clk);
        #1 wp = 1'b0;
    endtask

    task automatic t_foreign_select();
        logic ok;
        twi_host_model_inst.send_start();
        twi_host_model_inst.send_byte({`TYPE_CODE, ~CS, 1'b0}, ok);
        check(ok, 1'b0);
        twi_host_model_inst.send_byte({4'h3, CS, 1'b1}, ok);
        check(ok, 1'b0);
        twi_host_model_inst.send_stop();
    endtask

    initial begin
        wp = 1'b0;
        resetn = 1'b0;
        repeat (20) @(posedge core_clk);
        #1 resetn = 1'b1;
        check(sda_oe, 1'b0);
        check(sda_o, 1'b1);
        check(busy, 1'b0);
        repeat (10) @(posedge core_clk);
        t_byte_write();
        t_page_cross();
        t_top_wrap();
        t_protect();
        t_foreign_select();
        finish_test();
    end
endmodule // tb_serial_eeprom_rw_sequencer
